// ===== hw/phy_regs_pkg.sv
// Notes on behaviour
// - Idle mode asserts once consecutive idle symbols reach the 4-bit threshold.
// - Skew status bits 7:4 show lane B alignment cycles, read-only, reset zero.
// - Skew status bits 3:0 show lane A alignment cycles; upper byte reads zero.
// - Strap snapshot one bit 15 shows strapped port mirroring enable.
// - Strap snapshot one bit 14 shows strapped speed downshift enable.
// - Strap snapshot one bit 13 reads 1 when clock output strapped off.
// - Bit 12 parallel MAC strapped off; bit 11 serial MAC strapped on.
// - Bit 10 auto crossover strapped off; bit 9 forced crossed wiring.
// - Strap snapshot one bit 8 reads 1 when half duplex strapped.
// - Bit 7 reads 1 when negotiation strapped off; bits 6 and 4 zero.
// - Strap snapshot one bit 5 returns the strapped negotiation select.
// - Strap snapshot one bits 3:0 return the strapped station address.
// - Strap snapshot two bit 10 shows strapped quick link drop enable.
// - Strap snapshot two bits 6:4 return strapped transmit delay low bits.
// - Strap snapshot two bits 2:0 return receive delay bits; bit 3 zero.
// - Sixteen-bit read-only pattern byte total, reset to zero.
// - Readable byte total freezes when control two bit 0 or 1 written.
// - With wrap select 0 the byte total saturates at 0xffff.
// - Control two bit 0 only locks; bit 1 locks and clears with overflow.
package phy_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IDLE_CFG = 8'h53;
  localparam logic [7:0] IDX_SKEW_STS = 8'h55;
  localparam logic [7:0] IDX_WRAP_SEL = 8'h16;
  localparam logic [7:0] IDX_STRAP_ONE = 8'h6e;
  localparam logic [7:0] IDX_STRAP_TWO = 8'h6f;
  localparam logic [7:0] IDX_BYTE_TOTAL = 8'h71;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h72;

  localparam logic [3:0] IDLE_THR_RST = 4'h5;
  localparam logic [11:0] IDLE_CFG_UPPER = 12'h205;
  localparam logic [15:0] BYTE_TOTAL_RST = 16'h0000;
  localparam logic [15:0] BYTE_TOTAL_MAX = 16'hffff;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_BYTE_OVF_BIT = 9;
  localparam int WRAP_SEL_BIT = 0;

  typedef struct packed {
    logic mirror_on;
    logic downshift_on;
    logic clock_output_off;
    logic parallel_mac_off;
    logic serial_mac_on;
    logic auto_crossover_off;
    logic forced_crossover;
    logic half_duplex;
    logic negotiation_off;
    logic negotiation_select;
    logic [3:0] station_address;
    logic quick_link_drop;
    logic [2:0] tx_delay_low;
    logic [2:0] rx_delay_low;
  } strap_pins_s;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_LOCK = 2'b01,
    CNT_LOCK_CLEAR = 2'b10
  } cnt_cmd_e;

  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = {22'h000000, idx, 2'b00};
  endfunction : reg_addr

endpackage : phy_regs_pkg

// ===== hw/strap_capture.sv
`timescale 1ns/10ps
`default_nettype none
module strap_capture
  import phy_regs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire strap_pins_s straps_in,
  output strap_pins_s held_out
);

  logic taken_ff;
  strap_pins_s held_ff;

  // Pins are sampled on the first edge after release, never under reset
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      taken_ff <= 1'b0;
    end else begin
      taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      held_ff <= '0;
    end else if (!taken_ff) begin
      held_ff <= straps_in;
    end
  end

  assign held_out = held_ff;

endmodule : strap_capture
`default_nettype wire

// ===== hw/pattern_byte_counter.sv
`timescale 1ns/10ps
`default_nettype none
module pattern_byte_counter
  import phy_regs_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic byte_seen_in,
  input wire logic wrap_select_in,
  input wire cnt_cmd_e cmd_in,
  output logic [WIDTH-1:0] frozen_total_out,
  output logic overflow_out
);

  logic [WIDTH-1:0] run_ff;
  logic [WIDTH-1:0] frozen_ff;
  logic ovf_ff;
  logic at_top;

  assign at_top = (run_ff == {WIDTH{1'b1}});

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      run_ff <= BYTE_TOTAL_RST[WIDTH-1:0];
    end else if (cmd_in == CNT_LOCK_CLEAR) begin
      run_ff <= '0;
    end else if (byte_seen_in && !(at_top && !wrap_select_in)) begin
      run_ff <= run_ff + 1'b1;
    end
  end

  // Overflow raised in the clearing cycle survives the clear
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ovf_ff <= 1'b0;
    end else if (byte_seen_in && at_top) begin
      ovf_ff <= 1'b1;
    end else if (cmd_in == CNT_LOCK_CLEAR) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      frozen_ff <= BYTE_TOTAL_RST[WIDTH-1:0];
    end else if (cmd_in != CNT_IDLE) begin
      frozen_ff <= run_ff;
    end
  end

  assign frozen_total_out = frozen_ff;
  assign overflow_out = ovf_ff;

endmodule : pattern_byte_counter
`default_nettype wire

// ===== hw/phy_status_config_registers.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module phy_status_config_registers
  import phy_regs_pkg::*;
#(
  parameter int TOTAL_WIDTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Receive path status
  input wire logic idle_symbol_in,
  input wire logic [3:0] lane_a_align_cycles_in,
  input wire logic [3:0] lane_b_align_cycles_in,
  input wire logic pattern_byte_in,
  input wire strap_pins_s straps_in,
  output logic idle_mode_out,
  output strap_pins_s pinset_out
);

  //////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic [31:0] rdata_ff;
  logic take;
  logic addr_hit;
  logic [7:0] a_idx;

  assign take = hsel_in && htrans_in[1] && hready_in;
  assign a_idx = haddr_in[9:2];
  // Anything outside the low kilobyte is unmapped
  assign addr_hit = (haddr_in[31:10] == 22'h000000);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && hwrite_in && addr_hit;
      wr_idx_ff <= a_idx;
    end
  end

  // No wait states; every access answers OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Writable fields

  logic [3:0] idle_run_threshold_ff;
  logic pattern_count_wrap_select_ff;
  logic wr_idle;
  logic wr_wrap;
  logic wr_ctrl;

  assign wr_idle = wr_pend_ff && (wr_idx_ff == IDX_IDLE_CFG);
  assign wr_wrap = wr_pend_ff && (wr_idx_ff == IDX_WRAP_SEL);
  assign wr_ctrl = wr_pend_ff && (wr_idx_ff == IDX_CTRL_TWO);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idle_run_threshold_ff <= IDLE_THR_RST;
    end else if (wr_idle) begin
      idle_run_threshold_ff <= hwdata_in[3:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pattern_count_wrap_select_ff <= 1'b0;
    end else if (wr_wrap) begin
      pattern_count_wrap_select_ff <= hwdata_in[WRAP_SEL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Idle run detector

  logic [3:0] idle_run_ff;
  logic [3:0] nxt_idle_run;
  logic idle_mode_ff;

  always_comb begin
    if (!idle_symbol_in) begin
      nxt_idle_run = 4'h0;
    end else if (idle_run_ff == 4'hf) begin
      nxt_idle_run = idle_run_ff;
    end else begin
      nxt_idle_run = idle_run_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idle_run_ff <= 4'h0;
    end else begin
      idle_run_ff <= nxt_idle_run;
    end
  end

  // A threshold change takes effect on the run already in progress
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idle_mode_ff <= 1'b0;
    end else begin
      idle_mode_ff <= idle_symbol_in &&
                      (nxt_idle_run >= idle_run_threshold_ff);
    end
  end

  assign idle_mode_out = idle_mode_ff;

  //////////////////////////////////////////////////////////////////////////
  // Lane alignment status

  logic [3:0] lane_a_align_cycles_ff;
  logic [3:0] lane_b_align_cycles_ff;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      lane_a_align_cycles_ff <= 4'h0;
      lane_b_align_cycles_ff <= 4'h0;
    end else begin
      lane_a_align_cycles_ff <= lane_a_align_cycles_in;
      lane_b_align_cycles_ff <= lane_b_align_cycles_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strap snapshot

  strap_pins_s pins;

  strap_capture u_straps (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .straps_in(straps_in),
    .held_out(pins)
  );

  assign pinset_out = pins;

  //////////////////////////////////////////////////////////////////////////
  // Pattern byte total

  cnt_cmd_e cnt_cmd;
  logic [TOTAL_WIDTH-1:0] pattern_byte_total;
  logic byte_ovf;

  // Clear outranks lock when both bits are written together
  always_comb begin
    if (wr_ctrl && hwdata_in[CTRL_CLEAR_BIT]) begin
      cnt_cmd = CNT_LOCK_CLEAR;
    end else if (wr_ctrl && hwdata_in[CTRL_LOCK_BIT]) begin
      cnt_cmd = CNT_LOCK;
    end else begin
      cnt_cmd = CNT_IDLE;
    end
  end

  pattern_byte_counter #(
    .WIDTH(TOTAL_WIDTH)
  ) u_bytes (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .byte_seen_in(pattern_byte_in),
    .wrap_select_in(pattern_count_wrap_select_ff),
    .cmd_in(cnt_cmd),
    .frozen_total_out(pattern_byte_total),
    .overflow_out(byte_ovf)
  );

  //////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [15:0] strap_one_word;
  logic [15:0] strap_two_word;
  logic [15:0] rd_word;

  // Strap words are read-only views; writes to them fall through
  always_comb begin
    strap_one_word = 16'h0000;
    strap_one_word[15] = pins.mirror_on;
    strap_one_word[14] = pins.downshift_on;
    strap_one_word[13] = pins.clock_output_off;
    strap_one_word[12] = pins.parallel_mac_off;
    strap_one_word[11] = pins.serial_mac_on;
    strap_one_word[10] = pins.auto_crossover_off;
    strap_one_word[9] = pins.forced_crossover;
    strap_one_word[8] = pins.half_duplex;
    strap_one_word[7] = pins.negotiation_off;
    strap_one_word[5] = pins.negotiation_select;
    strap_one_word[3:0] = pins.station_address;
  end

  always_comb begin
    strap_two_word = 16'h0000;
    strap_two_word[10] = pins.quick_link_drop;
    strap_two_word[6:4] = pins.tx_delay_low;
    strap_two_word[2:0] = pins.rx_delay_low;
  end

  always_comb begin
    rd_word = 16'h0000;
    if (addr_hit) begin
      unique case (a_idx)
        IDX_IDLE_CFG: rd_word = {IDLE_CFG_UPPER, idle_run_threshold_ff};
        IDX_SKEW_STS: begin
          rd_word = {8'h00, lane_b_align_cycles_ff,
                     lane_a_align_cycles_ff};
        end
        IDX_WRAP_SEL: rd_word[WRAP_SEL_BIT] = pattern_count_wrap_select_ff;
        IDX_STRAP_ONE: rd_word = strap_one_word;
        IDX_STRAP_TWO: rd_word = strap_two_word;
        IDX_BYTE_TOTAL: rd_word = pattern_byte_total;
        IDX_CTRL_TWO: rd_word[CTRL_BYTE_OVF_BIT] = byte_ovf;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Read data is sampled in the address phase and held for the data phase
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rdata_ff <= 32'h00000000;
    end else if (take && !hwrite_in) begin
      rdata_ff <= {16'h0000, rd_word};
    end
  end

  assign hrdata_out = rdata_ff;

endmodule : phy_status_config_registers
`default_nettype wire

// ===== testbench/phy_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module phy_regs_chk
  import phy_regs_pkg::*;
#(
  parameter int TOTAL_WIDTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic idle_symbol_in,
  input wire logic idle_mode_out,
  input wire strap_pins_s straps_in,
  input wire strap_pins_s pinset_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic rd_go;
  logic [15:0] one_v;
  assign rd_go = hsel_in && htrans_in[1] && !hwrite_in;
  // Software view of the first snapshot, bits 6 and 4 held zero
  assign one_v = {pinset_out[20:12], 1'b0,
    pinset_out.negotiation_select, 1'b0, pinset_out.station_address};
  ////////////////////////////////////////
  chk_ready_high:
    assert property (hreadyout_out) else $error("hready low");
  chk_resp_okay:
    assert property (!hresp_out) else $error("error response");
  chk_idle_drop:
    assert property (!idle_symbol_in |=> !idle_mode_out)
    else $error("idle mode held without idle");
  chk_idle_cause:
    assert property (idle_mode_out |-> $past(idle_symbol_in))
    else $error("idle mode without idle symbol");
  chk_strap_load:
    assert property ($rose(reset_n_in) |=> pinset_out == $past(straps_in))
    else $error("straps not captured");
  chk_strap_hold:
    assert property ($past(reset_n_in, 2) |-> $stable(pinset_out))
    else $error("straps changed");
  chk_unmapped_zero:
    assert property (rd_go && haddr_in[31:10] != 0 |=> hrdata_out == 0)
    else $error("unmapped read not zero");
  chk_upper_zero:
    assert property (rd_go |=> hrdata_out[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_strap_image:
    assert property (rd_go && haddr_in == 32'h000001b8
      |=> hrdata_out == {16'h0000, $past(one_v)})
    else $error("strap one image wrong");
endmodule : phy_regs_chk

bind phy_status_config_registers phy_regs_chk #(
  .TOTAL_WIDTH(TOTAL_WIDTH)
) chk_u (.core_clk_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hreadyout_out, .hresp_out, .hrdata_out, .idle_symbol_in,
  .idle_mode_out, .straps_in, .pinset_out);
`default_nettype wire

// ===== testbench/phy_status_config_registers_tb.sv
`timescale 1ns/10ps
`default_nettype none
module phy_status_config_registers_tb
  import phy_regs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic idle = 1'b0;
  logic pbyte = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rdata;
  logic [3:0] lane_a = 4'h3;
  logic [3:0] lane_b = 4'hc;
  strap_pins_s straps = strap_pins_s'(21'h15a6c9);
  strap_pins_s pins;
  logic hready;
  logic hresp;
  logic imode;
  int errors = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  phy_status_config_registers dut_u (.core_clk_in(clk), .reset_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .idle_symbol_in(idle),
    .lane_a_align_cycles_in(lane_a), .lane_b_align_cycles_in(lane_b),
    .pattern_byte_in(pbyte), .straps_in(straps), .idle_mode_out(imode),
    .pinset_out(pins));
  ////////////////////////////////////////
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : cmp
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask : bus
  task rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp(nm, e, rdata);
  endtask : rd
  task bytes(input int n);
    pbyte <= 1'b1;
    repeat (n) @(posedge clk);
    pbyte <= 1'b0;
  endtask : bytes
  task t_straps;
    logic [31:0] one;
    logic [31:0] two;
    one = {16'h0, straps[20:12], 1'b0, straps.negotiation_select, 1'b0,
      straps.station_address};
    two = {21'h0, straps.quick_link_drop, 3'h0, straps.tx_delay_low, 1'b0,
      straps.rx_delay_low};
    rd("strap_one", 32'h1b8, one);
    rd("strap_two", 32'h1bc, two);
    straps <= ~straps;
    bus(32'h1bc, 1'b1, 32'hffff);
    rd("strap_keep", 32'h1bc, two);
  endtask : t_straps
  task t_regs;
    rd("idle_cfg", 32'h14c, 32'h2055);
    bus(32'h154, 1'b1, 32'hffff);
    rd("skew", 32'h154, {24'h0, lane_b, lane_a});
    rd("unmapped", 32'h400, 32'h0);
    rd("wrap_rst", 32'h58, 32'h0);
    bus(32'h58, 1'b1, 32'h1);
    rd("wrap_set", 32'h58, 32'h1);
    // Saturation run below needs the saturating mode back
    bus(32'h58, 1'b1, 32'h0);
    rd("wrap_clr", 32'h58, 32'h0);
  endtask : t_regs
  task t_idle;
    bus(32'h14c, 1'b1, 32'h3);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("idle_early", 32'h0, {31'h0, imode});
    @(posedge clk);
    cmp("idle_on", 32'h1, {31'h0, imode});
    idle <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("idle_off", 32'h0, {31'h0, imode});
  endtask : t_idle
  task t_count;
    rd("total_rst", 32'h1c4, 32'h0);
    bytes(5);
    bus(32'h1c8, 1'b1, 32'h1);
    rd("total_lock", 32'h1c4, 32'h5);
    bytes(3);
    rd("total_frozen", 32'h1c4, 32'h5);
    bus(32'h1c8, 1'b1, 32'h2);
    rd("total_clr", 32'h1c4, 32'h8);
    bus(32'h1c8, 1'b1, 32'h1);
    rd("total_zero", 32'h1c4, 32'h0);
    // Long run past the top is the only way to see saturation
    bytes(65540);
    bus(32'h1c8, 1'b1, 32'h1);
    rd("total_sat", 32'h1c4, 32'hffff);
    bus(32'h1c8, 1'b0, 32'h0);
    cmp("ovf_set", 32'h200, rdata & 32'h200);
    bus(32'h1c8, 1'b1, 32'h2);
    bus(32'h1c8, 1'b0, 32'h0);
    cmp("ovf_clr", 32'h0, rdata & 32'h200);
  endtask : t_count
  task complete_run;
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_straps;
    t_regs;
    t_idle;
    t_count;
    complete_run;
  end
  initial begin
    #4000000;
    errors++;
    complete_run;
  end
endmodule : phy_status_config_registers_tb
`default_nettype wire
